/* File: rtl/pds_cfg.svh */
// constants for the pll divider and base clock selector
`ifndef PDS_CFG_SVH
`define PDS_CFG_SVH
`define PDS_RST_PLL_ON     1'h1
`define PDS_RST_BSEL       1'h0
`define PDS_RST_PRESCALE   2'h0
`define PDS_RST_RANGE_POW  2'h0
`define PDS_RST_MULT       12'h040
`define PDS_RST_VRS        8'h40
`define PDS_RST_RDS        4'h1
`define PDS_NEW_EDGES      2'h2
`define PDS_BUS_DIV        3'h4
`endif

/* File: rtl/pds_pkg.sv */
// types for the pll divider and base clock selector
package pds_pkg;
  typedef enum logic [1:0] {PDS_RUN, PDS_STOP_OLD, PDS_WAIT_NEW} pds_sel_state_t;
endpackage

/* File: rtl/pds_clock_select.sv */
// pll factor registers, zero exceptions and glitch-free base clock selector
//
// Notes on behaviour
// R1: bus clock is a quarter of source
// R2: vco ratio is two-power-P times N over R
// R3: software picks P 0..3 to bound N
// R4: software picks E from vco band, never 3
// R5: center frequency is L times two-power-E steps
// R6: control holds P in prescale field
// R7: control holds E in range field
// R8: N stored across low and high parts
// R9: L and R stored as binary
// R10: zero R or N acts as one
// R11: zero L disables pll, forces crystal
// R12: switch waits few edges, output static
// R13: selected source halved for clean duty
// R14: vco select refused while pll off
// R15: pll stays on while vco selected
// R16: power and select never change together
// R17: software prefers 32.768 kHz reference, R one
// R18: select one routes vco, zero crystal
// R19: programming ignored while pll on
// R20: reset turns pll on, selects crystal
// R21: old clock stopped low before new starts
// R22: source clocks pass two-flop synchronisers
`timescale 1ns/1ps
`include "pds_cfg.svh"
module pds_clock_select
  import pds_pkg::*;
(
  input  wire logic        clk_i,             // 40 MHz system clock
  input  wire logic        reset_i,           // synchronous reset, high
  input  wire logic        ce_i,              // clock enable, freezes all state
  input  wire logic        crystal_clock_i,   // crystal clock, sampled
  input  wire logic        vco_clock_i,       // vco clock, sampled
  input  wire logic        ctl_wr_i,          // control write strobe
  input  wire logic        pll_power_on_i,    // written pll on bit
  input  wire logic        base_clock_sel_i,  // written base select bit
  input  wire logic        prog_wr_i,         // programming write strobe
  input  wire logic [1:0]  prescale_i,        // written P
  input  wire logic [1:0]  range_pow_i,       // written E
  input  wire logic [11:0] mult_i,            // written N
  input  wire logic [7:0]  vrs_i,             // written L
  input  wire logic [3:0]  rds_i,             // written R
  output logic             pll_power_on_o,    // stored pll on bit
  output logic             base_clock_sel_o,  // stored base select bit
  output logic [1:0]       prescale_o,        // stored P
  output logic [1:0]       range_pow_o,       // stored E
  output logic [11:0]      mult_o,            // stored N
  output logic [7:0]       vrs_o,             // stored L
  output logic [3:0]       rds_o,             // stored R
  output logic             pll_enable_o,      // pll really running
  output logic [11:0]      eff_mult_o,        // N as divided
  output logic [3:0]       eff_ref_div_o,     // R as divided
  output logic [14:0]      fb_ratio_o,        // two-power-P times N
  output logic [10:0]      center_steps_o,    // center in 38.4 kHz steps
  output logic             base_clock_out_o,  // base clock to system
  output logic             bus_clock_o,       // base clock halved
  output logic             sel_busy_o         // source transition in progress
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic        pll_on_q, pll_on_d, bsel_q, bsel_d;
  logic [1:0]  pre_q, pre_d, rpow_q, rpow_d;
  logic [11:0] mul_q, mul_d;
  logic [7:0]  vrs_q, vrs_d;
  logic [3:0]  rds_q, rds_d;
  logic [11:0] rds_wide;

  function automatic logic [11:0] pds_zero_as_one(input logic [11:0] v);
    pds_zero_as_one = (v == 12'h000) ? 12'h001 : v; // R10
  endfunction

  always_comb begin
    pll_on_d = pll_on_q;
    bsel_d   = bsel_q;
    pre_d    = pre_q;
    rpow_d   = rpow_q;
    mul_d    = mul_q;
    vrs_d    = vrs_q;
    rds_d    = rds_q;
    if (ctl_wr_i) begin
      if (!base_clock_sel_i || (pll_on_q && vrs_q != 8'h00)) begin // R14
        bsel_d = base_clock_sel_i;
      end
      // a write that moves the select keeps the power bit, so both never move at once
      if ((pll_power_on_i || !bsel_q) && (bsel_d == bsel_q)) begin // R15 R16
        pll_on_d = pll_power_on_i;
      end
    end
    if (prog_wr_i && !pll_on_q) begin // R19
      pre_d = prescale_i; // R6
      rpow_d = range_pow_i; // R7
      mul_d = mult_i; // R8
      vrs_d = vrs_i; // R9
      rds_d = rds_i; // R9
    end
    if (vrs_d == 8'h00) begin
      bsel_d = 1'h0; // R11
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pll_on_q <= `PDS_RST_PLL_ON; // R20
      bsel_q   <= `PDS_RST_BSEL; // R20
      pre_q    <= `PDS_RST_PRESCALE;
      rpow_q   <= `PDS_RST_RANGE_POW;
      mul_q    <= `PDS_RST_MULT;
      vrs_q    <= `PDS_RST_VRS;
      rds_q    <= `PDS_RST_RDS;
    end else if (ce_i) begin
      pll_on_q <= pll_on_d;
      bsel_q   <= bsel_d;
      pre_q    <= pre_d;
      rpow_q   <= rpow_d;
      mul_q    <= mul_d;
      vrs_q    <= vrs_d;
      rds_q    <= rds_d;
    end
  end

  assign pll_power_on_o   = pll_on_q;
  assign base_clock_sel_o = bsel_q;
  assign prescale_o       = pre_q;
  assign range_pow_o      = rpow_q;
  assign mult_o           = mul_q;
  assign vrs_o            = vrs_q;
  assign rds_o            = rds_q;
  assign pll_enable_o     = pll_on_q && (vrs_q != 8'h00); // R11
  assign eff_mult_o       = pds_zero_as_one(mul_q); // R10
  assign rds_wide         = pds_zero_as_one({8'h00, rds_q}); // R10
  assign eff_ref_div_o    = rds_wide[3:0]; // R10
  assign fb_ratio_o       = {3'h0, eff_mult_o} << pre_q; // R2
  assign center_steps_o   = {3'h0, vrs_q} << rpow_q; // R5

  ////////////////////////////////////////////////////////////////////////////
  // source synchronisers and edge detect
  logic [2:0] xs_q, xs_d, vs_q, vs_d;
  logic       x_rise, v_rise;

  always_comb begin
    xs_d = {xs_q[1:0], crystal_clock_i}; // R22
    vs_d = {vs_q[1:0], vco_clock_i}; // R22
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      xs_q <= 3'h0;
      vs_q <= 3'h0;
    end else if (ce_i) begin
      xs_q <= xs_d;
      vs_q <= vs_d;
    end
  end

  // bit 0 is the first stage and is only read by bit 1
  assign x_rise = xs_q[1] && !xs_q[2];
  assign v_rise = vs_q[1] && !vs_q[2] && pll_enable_o;

  ////////////////////////////////////////////////////////////////////////////
  // transition control and dividers
  pds_sel_state_t st_q, st_d;
  logic           cur_q, cur_d, base_q, base_d, bus_q, bus_d;
  logic [1:0]     cnt_q, cnt_d;
  logic           old_rise, new_rise;

  assign old_rise = cur_q ? v_rise : x_rise;
  assign new_rise = cur_q ? x_rise : v_rise;

  always_comb begin
    st_d   = st_q;
    cur_d  = cur_q;
    base_d = base_q;
    bus_d  = bus_q;
    cnt_d  = cnt_q;
    unique case (st_q)
      PDS_RUN: begin
        if (old_rise) begin
          base_d = !base_q; // R13 R18
        end
        if (bsel_q != cur_q) begin
          st_d = PDS_STOP_OLD;
        end
      end
      PDS_STOP_OLD: begin
        // finish a high phase so the old clock parks low
        if (!base_q) begin // R21
          st_d  = PDS_WAIT_NEW;
          cnt_d = 2'h0;
        end else if (old_rise) begin
          base_d = 1'b0;
        end
      end
      PDS_WAIT_NEW: begin
        if (new_rise) begin // R12
          cnt_d = cnt_q + 2'h1;
          if (cnt_d == `PDS_NEW_EDGES) begin
            cur_d = !cur_q;
            st_d  = PDS_RUN;
          end
        end
      end
    endcase
    if (base_q && !base_d) begin
      bus_d = !bus_q; // R1
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_q   <= PDS_RUN;
      cur_q  <= 1'b0;
      base_q <= 1'b0;
      bus_q  <= 1'b0;
      cnt_q  <= 2'h0;
    end else if (ce_i) begin
      st_q   <= st_d;
      cur_q  <= cur_d;
      base_q <= base_d;
      bus_q  <= bus_d;
      cnt_q  <= cnt_d;
    end
  end

  assign base_clock_out_o = base_q;
  assign bus_clock_o      = bus_q;
  assign sel_busy_o       = (st_q != PDS_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_enter_wait;
    (st_q == PDS_STOP_OLD) && !base_q && ce_i ##1 (st_q == PDS_WAIT_NEW);
  endsequence

  a_wait_static: assert property ((st_q == PDS_WAIT_NEW) |=> $stable(base_q)) // R12
    else $error("base clock moved during transition");
  a_park_low: assert property (s_enter_wait |-> !base_q) // R21
    else $error("old clock not parked low");
  a_vco_needs_pll: assert property (bsel_q |-> pll_on_q && vrs_q != 8'h00) // R14
    else $error("vco selected without running pll");
  a_pll_held: assert property (bsel_q && ce_i |=> pll_on_q) // R15
    else $error("pll dropped while vco selected");
  a_no_joint: assert property (ce_i |=> !($changed(pll_on_q) && $changed(bsel_q))) // R16
    else $error("power and select changed together");
  a_prog_locked: assert property (pll_on_q |=> $stable(mul_q) && $stable(vrs_q) && $stable(rds_q)) // R19
    else $error("programming changed while pll on");
  a_zero_one: assert property (eff_mult_o != 12'h000 && eff_ref_div_o != 4'h0) // R10
    else $error("zero divide factor used");
  a_run_toggle: assert property ((st_q == PDS_RUN) && ce_i && !old_rise |=> $stable(base_q)) // R13
    else $error("base toggled without source edge");
  a_reset_vals: assert property ($past(reset_i) |-> pll_on_q && !bsel_q) // R20
    else $error("bad state after reset");
  a_zero_l: assert property (vrs_q == 8'h00 |-> !pll_enable_o && !bsel_q) // R11
    else $error("zero range left pll enabled");
endmodule

/* File: verif/pds_sink_model.sv */
// base clock consumer: counts clock rises and the shortest base high
`timescale 1ns/1ps
module pds_sink_model (
  input  wire logic       clk_i,    // system clock
  input  wire logic       en_i,     // counting window, low clears
  input  wire logic       base_i,   // base clock in
  input  wire logic       bus_i,    // bus clock in
  output logic [7:0]      base_n_o, // base rises in window
  output logic [7:0]      bus_n_o,  // bus rises in window
  output logic [7:0]      min_hi_o  // shortest base high, in clk
);
  logic       base_q = 1'h0;
  logic       bus_q  = 1'h0;
  logic [7:0] hi_q   = 8'h00;
  logic [7:0] bn_q   = 8'h00;
  logic [7:0] un_q   = 8'h00;
  logic [7:0] mh_q   = 8'hFF;
  assign base_n_o = bn_q;
  assign bus_n_o  = un_q;
  assign min_hi_o = mh_q;
  always @(posedge clk_i) begin
    base_q <= base_i;
    bus_q <= bus_i;
    hi_q <= base_i ? hi_q + 8'h01 : 8'h00;
    // a runt shows as a short high
    if (!base_i && base_q && hi_q < mh_q) mh_q <= hi_q;
    bn_q <= en_i ? bn_q + {7'h00, base_i & ~base_q} : 8'h00;
    un_q <= en_i ? un_q + {7'h00, bus_i & ~bus_q} : 8'h00;
  end
endmodule

/* File: verif/pds_clock_select_test.sv */
// self-checking bench for the pll factors and base clock selector
`timescale 1ns/1ps
module pds_clock_select_test;
  logic clk_i = 1'h0, reset_i = 1'h1, xc = 1'h0, vc = 1'h0, cw = 1'h0, pon = 1'h0, bsel = 1'h0, pw = 1'h0;
  logic en = 1'h0, ce = 1'h1;
  logic [1:0] pre = 2'h0, rp = 2'h0;
  logic [11:0] mul = 12'h000;
  logic [7:0] vrs = 8'h00, bn, un, mh;
  logic [3:0] rds = 4'h0;
  logic [2:0] xcnt = 3'h0, vcnt = 3'h0;
  wire logic pon_o, bsel_o, en_o, base, bus, busy;
  wire logic [1:0] pre_o, rp_o;
  wire logic [11:0] mul_o, emul;
  wire logic [7:0] vrs_o;
  wire logic [3:0] rds_o, eref;
  wire logic [14:0] fb;
  wire logic [10:0] ctr;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  pds_clock_select dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .crystal_clock_i(xc), .vco_clock_i(vc),
    .ctl_wr_i(cw), .pll_power_on_i(pon), .base_clock_sel_i(bsel), .prog_wr_i(pw), .prescale_i(pre),
    .range_pow_i(rp), .mult_i(mul), .vrs_i(vrs), .rds_i(rds), .pll_power_on_o(pon_o), .base_clock_sel_o(bsel_o),
    .prescale_o(pre_o), .range_pow_o(rp_o), .mult_o(mul_o), .vrs_o(vrs_o), .rds_o(rds_o), .pll_enable_o(en_o),
    .eff_mult_o(emul), .eff_ref_div_o(eref), .fb_ratio_o(fb), .center_steps_o(ctr), .base_clock_out_o(base),
    .bus_clock_o(bus), .sel_busy_o(busy));
  pds_sink_model sink (.clk_i(clk_i), .en_i(en), .base_i(base), .bus_i(bus), .base_n_o(bn), .bus_n_o(un),
    .min_hi_o(mh));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////
  // crystal period 8 clk, vco period 6 clk
  always @(posedge clk_i) begin
    xcnt <= (xcnt == 3'h3) ? 3'h0 : xcnt + 3'h1;
    if (xcnt == 3'h3) xc <= ~xc;
    vcnt <= (vcnt == 3'h2) ? 3'h0 : vcnt + 3'h1;
    if (vcnt == 3'h2) vc <= ~vc;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize();
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic ctl(input logic p, input logic b);
    @(posedge clk_i);
    cw <= 1'h1;
    pon <= p;
    bsel <= b;
    @(posedge clk_i);
    cw <= 1'h0;
    #1;
  endtask
  task automatic prog(input logic [1:0] p, input logic [1:0] e, input logic [11:0] n, input logic [7:0] l,
                      input logic [3:0] r);
    @(posedge clk_i);
    {pw, pre, rp, mul, vrs, rds} <= {1'h1, p, e, n, l, r};
    @(posedge clk_i);
    pw <= 1'h0;
    #1;
  endtask
  task automatic settle();
    int k;
    // look 1 ns after each edge so the flop has settled
    for (k = 0; k < 20 && busy !== 1'h1; k++) begin
      @(posedge clk_i);
      #1;
    end
    check(busy, 1'h1);
    for (k = 0; k < 60 && busy !== 1'h0; k++) begin
      @(posedge clk_i);
      #1;
    end
    check(busy, 1'h0);
  endtask
  task automatic measure(input logic [7:0] exp);
    @(posedge clk_i);
    en <= 1'h0;
    @(posedge clk_i);
    en <= 1'h1;
    repeat (240) @(posedge clk_i);
    #1;
    check(bn >= exp - 8'h01 && bn <= exp + 8'h01, 1'h1);
    check(un >= exp / 2 - 8'h01 && un <= exp / 2 + 8'h01, 1'h1);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'h0;
    #1;
    check({pon_o, bsel_o, pre_o, rp_o, busy}, 7'h40);
    check({mul_o, rds_o}, 16'h0401);
    prog(2'h3, 2'h2, 12'h000, 8'h80, 4'h0);
    check(mul_o, 12'h040);
    ctl(1'h0, 1'h0);
    prog(2'h3, 2'h2, 12'h000, 8'h80, 4'h0);
    check({pon_o, pre_o, rp_o, vrs_o}, 13'h0E80);
    check({mul_o, rds_o}, 16'h0000);
    check({emul, eref}, 16'h0011);
    check(fb, 15'h0008);
    check(ctr, 11'h200);
    ctl(1'h0, 1'h1);
    check(bsel_o, 1'h0);
    ctl(1'h1, 1'h1);
    check({pon_o, bsel_o}, 2'h2);
    check(en_o, 1'h1);
    measure(8'h0F);
    // select with power off asked in one write: select moves, power stays
    ctl(1'h0, 1'h1);
    check({pon_o, bsel_o}, 2'h3);
    settle();
    measure(8'h14);
    ctl(1'h0, 1'h1);
    check(pon_o, 1'h1);
    check(mh >= 8'h06, 1'h1);
    ctl(1'h1, 1'h0);
    settle();
    ctl(1'h0, 1'h0);
    prog(2'h0, 2'h0, 12'h0F5, 8'h00, 4'h1);
    check({emul, eref}, 16'h0F51);
    check(fb, 15'h00F5);
    check(ctr, 11'h000);
    ctl(1'h1, 1'h0);
    check(en_o, 1'h0);
    ctl(1'h1, 1'h1);
    check(bsel_o, 1'h0);
    // clock enable low must freeze the power bit against a write
    @(posedge clk_i);
    ce <= 1'h0;
    ctl(1'h0, 1'h0);
    check(pon_o, 1'h1);
    @(posedge clk_i);
    ce <= 1'h1;
    summarize();
  end
endmodule
